/* File: hw/srip_pkg.sv */
// package: constants, register map and carrier types of the scan refreshed io port
package srip_pkg;
  // clock and time base
  localparam int CLK_NS = 50;
  localparam int TICK_NS = 10000;                  // filter time base, 10 us
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;   // 200 cycles per tick
  // point counts and input classes
  localparam int N_IN = 16;
  localparam int N_HS = 6;
  localparam int N_STD = 10;
  localparam int N_OUT = 8;
  // filter times in microseconds as printed, high-speed then standard
  localparam int HS_US_0 = 10;
  localparam int HS_US_1 = 100;
  localparam int HS_US_2 = 200;
  localparam int HS_US_3 = 400;
  localparam int HS_US_4 = 600;
  localparam int HS_US_5 = 1000;
  localparam int STD_US_0 = 100;
  localparam int STD_US_1 = 1000;
  localparam int STD_US_2 = 5000;
  localparam int STD_US_3 = 10000;
  localparam int STD_US_4 = 20000;
  localparam int STD_US_5 = 70000;
  localparam int CNT_W = 13;                       // holds 7000 ticks
  localparam int CODE_W = 3;
  localparam int CODE_STRIDE = 4;                  // one nibble per input
  localparam logic [2:0] CODE_MAX = 3'h5;
  // register byte offsets
  localparam logic [5:0] OFS_IN_IMAGE = 6'h00;
  localparam logic [5:0] OFS_IN_DIRECT = 6'h04;
  localparam logic [5:0] OFS_OUT_IMAGE = 6'h08;
  localparam logic [5:0] OFS_OUT_DIRECT = 6'h0C;
  localparam logic [5:0] OFS_REFRESH_IN = 6'h10;
  localparam logic [5:0] OFS_REFRESH_OUT = 6'h14;
  localparam logic [5:0] OFS_FILT_LO = 6'h18;
  localparam logic [5:0] OFS_FILT_HI = 6'h1C;
  localparam logic [5:0] OFS_OUT_CFG = 6'h20;
  localparam logic [5:0] OFS_STATUS = 6'h24;
  // field positions
  localparam int DIR_MASK_POS = 8;                 // direct write select mask
  localparam int RNG_FIRST_POS = 0;                // partial refresh first point
  localparam int RNG_LAST_POS = 8;                 // partial refresh last point
  localparam int CFG_FN_POS = 8;                   // function ownership mask
  // reset values
  localparam logic [31:0] FILT_LO_RST = 32'h3355_5555; // hs 1 ms, std 10 ms
  localparam logic [31:0] FILT_HI_RST = 32'h3333_3333;
  localparam logic [7:0] HOLD_RST = 8'h00;        // all outputs clear on stop
  localparam logic [7:0] FN_RST = 8'h00;          // all outputs general purpose
  // avalon request carrier
  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } srip_avs_req_t;
endpackage : srip_pkg

/* File: hw/srip_port.sv */
// scan refreshed discrete io port with avalon-mm register access
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module srip_port #(
  parameter int TICK_CYCLES = srip_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire srip_pkg::srip_avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] input_points,
  output logic [7:0] output_points,
  input wire logic scan_end,
  input wire logic prog_stop_error,
  input wire logic [7:0] fn_out,
  output logic [15:0] fn_in
);
  ////////////////////////////////////////////////////////////////////////////////
  // filter time in microseconds of a high-speed input for a code
  function automatic int hs_us(input logic [2:0] code);
    int us;
    case (code)
      3'h0: us = srip_pkg::HS_US_0;
      3'h1: us = srip_pkg::HS_US_1;
      3'h2: us = srip_pkg::HS_US_2;
      3'h3: us = srip_pkg::HS_US_3;
      3'h4: us = srip_pkg::HS_US_4;
      default: us = srip_pkg::HS_US_5; // codes 5 to 7 share the longest time
    endcase
    return us;
  endfunction : hs_us

  // filter time in microseconds of a standard input for a code
  function automatic int std_us(input logic [2:0] code);
    int us;
    case (code)
      3'h0: us = srip_pkg::STD_US_0;
      3'h1: us = srip_pkg::STD_US_1;
      3'h2: us = srip_pkg::STD_US_2;
      3'h3: us = srip_pkg::STD_US_3;
      3'h4: us = srip_pkg::STD_US_4;
      default: us = srip_pkg::STD_US_5; // codes 5 to 7 share the longest time
    endcase
    return us;
  endfunction : std_us

  // filter limit in ticks for a class and a code
  function automatic logic [12:0] lim_ticks(input logic hs, input logic [2:0] code);
    int us;
    us = hs ? hs_us(code) : std_us(code);
    return 13'((us * 1000) / srip_pkg::TICK_NS);
  endfunction : lim_ticks

  // bitwise merge of an output byte: selected bits take the new value
  function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [7:0] new_v, input logic [7:0] sel);
    return (old_v & ~sel) | (new_v & sel);
  endfunction : merge8

  // bitwise merge of an input word: selected bits take the new value
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [15:0] sel);
    return (old_v & ~sel) | (new_v & sel);
  endfunction : merge16

  // mask of points first..last, empty when first is above last
  function automatic logic [7:0] range_mask(input logic [2:0] first, input logic [2:0] last);
    logic [7:0] m;
    m = 8'h00;
    for (int k = 0; k < srip_pkg::N_OUT; k++) begin
      m[k] = (3'(k) >= first) && (3'(k) <= last);
    end
    return m;
  endfunction : range_mask

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] in_filt;
  logic [15:0] in_image;
  logic [7:0] out_image;
  logic [7:0] out_pins;
  logic [31:0] filt_lo;
  logic [31:0] filt_hi;
  logic [7:0] hold_mask;
  logic [7:0] fn_mask;
  logic stopped;
  logic ack;
  logic [7:0] tick_cnt;
  logic tick;
  logic [12:0] fcnt [16];

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic req = avs_req.read | avs_req.write;
  wire logic wr = avs_req.write & ack;
  wire logic [5:0] adr = {avs_req.address[5:2], 2'b00};
  wire logic [31:0] wd = avs_req.writedata;
  wire logic wr_img = wr && adr == srip_pkg::OFS_OUT_IMAGE;
  wire logic wr_dir = wr && adr == srip_pkg::OFS_OUT_DIRECT;
  wire logic wr_rin = wr && adr == srip_pkg::OFS_REFRESH_IN;
  wire logic wr_rout = wr && adr == srip_pkg::OFS_REFRESH_OUT;
  wire logic wr_flo = wr && adr == srip_pkg::OFS_FILT_LO;
  wire logic wr_fhi = wr && adr == srip_pkg::OFS_FILT_HI;
  wire logic wr_cfg = wr && adr == srip_pkg::OFS_OUT_CFG;
  wire logic [7:0] dir_sel = wd[srip_pkg::DIR_MASK_POS +: 8];
  wire logic [7:0] rng_sel = range_mask(wd[srip_pkg::RNG_FIRST_POS +: 3],
                                        wd[srip_pkg::RNG_LAST_POS +: 3]);

  // wait one cycle, then answer; the answer edge is the one with waitrequest low
  assign avs_waitrequest = req & ~ack;

  // read mux
  logic [31:0] next_rd;
  always_comb begin
    case (adr)
      srip_pkg::OFS_IN_IMAGE: next_rd = {16'h0000, in_image};
      srip_pkg::OFS_IN_DIRECT: next_rd = {16'h0000, in_filt};
      srip_pkg::OFS_OUT_IMAGE: next_rd = {24'h000000, out_image};
      srip_pkg::OFS_OUT_DIRECT: next_rd = {24'h000000, output_points};
      srip_pkg::OFS_FILT_LO: next_rd = filt_lo;
      srip_pkg::OFS_FILT_HI: next_rd = filt_hi;
      srip_pkg::OFS_OUT_CFG: next_rd = {16'h0000, fn_mask, hold_mask};
      srip_pkg::OFS_STATUS: next_rd = {31'h00000000, stopped};
      default: next_rd = 32'h00000000;
    endcase
  end

  // bus handshake and read data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack <= req & ~ack;
      if (avs_req.read & ~ack) begin
        avs_readdata <= next_rd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // filter time base
  assign tick = tick_cnt == 8'(TICK_CYCLES - 1);
  always_ff @(posedge clk_sys) begin
    if (srst || tick) begin
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end

  // per-point debounce: a change is accepted once stable for the set time
  wire logic [63:0] codes = {filt_hi, filt_lo};

  // per-point limit in ticks; the lowest points use the high-speed table
  logic [12:0] lim [16];
  always_comb begin
    for (int i = 0; i < srip_pkg::N_IN; i++) begin
      lim[i] = lim_ticks(i < srip_pkg::N_HS, codes[i * srip_pkg::CODE_STRIDE +: srip_pkg::CODE_W]);
    end
  end

  // counters restart whenever the pin agrees with the accepted state again
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < srip_pkg::N_IN; i++) begin
      if (srst) begin
        fcnt[i] <= 13'h0000;
        in_filt[i] <= 1'b0;
      end else if (input_points[i] == in_filt[i]) begin
        fcnt[i] <= 13'h0000;
      end else if (tick) begin
        if (fcnt[i] + 13'h0001 >= lim[i]) begin
          in_filt[i] <= input_points[i];
          fcnt[i] <= 13'h0000;
        end else begin
          fcnt[i] <= fcnt[i] + 13'h0001;
        end
      end
    end
  end

  // every filtered point is offered to the functions and to the images
  assign fn_in = in_filt;

  ////////////////////////////////////////////////////////////////////////////////
  // input image
  wire logic [15:0] rin_sel = wd[15:0];
  wire logic [15:0] in_mix = merge16(in_image, in_filt, rin_sel);

  // a scan end copies every point and so beats a partial refresh in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      in_image <= 16'h0000;
    end else if (scan_end) begin
      in_image <= in_filt;
    end else if (wr_rin) begin
      in_image <= in_mix;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // filter codes of points 0 to 7
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      filt_lo <= srip_pkg::FILT_LO_RST;
    end else if (wr_flo) begin
      filt_lo <= wd;
    end
  end

  // filter codes of points 8 to 15
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      filt_hi <= srip_pkg::FILT_HI_RST;
    end else if (wr_fhi) begin
      filt_hi <= wd;
    end
  end

  // stop behaviour and function ownership of the outputs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hold_mask <= srip_pkg::HOLD_RST;
      fn_mask <= srip_pkg::FN_RST;
    end else if (wr_cfg) begin
      hold_mask <= wd[7:0];
      fn_mask <= wd[srip_pkg::CFG_FN_POS +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output image and pins; program writes are dropped once stopped
  wire logic frozen = prog_stop_error | stopped;
  wire logic stop_now = prog_stop_error & ~stopped;
  wire logic [7:0] img_wr = wr_dir ? merge8(out_image, wd[7:0], dir_sel) : wd[7:0];
  wire logic [7:0] pins_dir = merge8(out_pins, wd[7:0], dir_sel);
  wire logic [7:0] pins_rng = merge8(out_pins, out_image, rng_sel);

  // sticky stop flag; only reset brings the outputs back
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stopped <= 1'b0;
    end else if (prog_stop_error) begin
      stopped <= 1'b1;
    end
  end

  // output image, written by the program until a stop
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_image <= 8'h00;
    end else if (!frozen && (wr_img || wr_dir)) begin
      out_image <= img_wr;
    end
  end

  // pin selection: the hold mask is applied once, at the stop, so later
  // hold mask writes cannot disturb held pins
  logic [7:0] next_pins;
  always_comb begin
    next_pins = out_pins;
    if (stop_now) begin
      next_pins = out_pins & hold_mask;
    end else if (stopped) begin
      next_pins = out_pins;
    end else if (scan_end) begin
      next_pins = out_image;
    end else if (wr_dir) begin
      next_pins = pins_dir;
    end else if (wr_rout) begin
      next_pins = pins_rng;
    end
  end

  // registered pins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_pins <= 8'h00;
    end else begin
      out_pins <= next_pins;
    end
  end

  // function-owned points bypass the image, others show the image pins
  assign output_points = (fn_out & fn_mask) | (out_pins & ~fn_mask);
endmodule : srip_port

/* File: testbench/srip_field.sv */
// field side model: switches that drive the input pins of the io port
`timescale 1ns/1ps
module srip_field (
  input wire logic clk_sys,
  input wire logic [15:0] sw,
  output logic [15:0] input_points
);
  // contacts settle one clock after a switch is thrown, never mid-cycle
  initial input_points = 16'h0000;
  always @(posedge clk_sys) begin
    input_points <= sw;
  end
endmodule : srip_field

/* File: testbench/srip_port_chk.sv */
// checker: bus handshake, pin update and filtered input steadiness of the io port
`timescale 1ns/1ps
module srip_port_chk #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire srip_pkg::srip_avs_req_t avs_req,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [15:0] input_points,
  input wire logic [7:0] output_points,
  input wire logic scan_end,
  input wire logic prog_stop_error,
  input wire logic [7:0] fn_out,
  input wire logic [15:0] fn_in
);
  logic rw;
  logic stop_q;
  // any bus request and a sticky copy of the stop input
  assign rw = avs_req.read | avs_req.write;
  always_ff @(posedge clk_sys) begin
    stop_q <= srst ? 1'b0 : (stop_q | prog_stop_error);
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////
  a_wait_one: assert property (rw && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  a_wait_new: assert property (rw && !$past(rw) |-> avs_waitrequest)
    else $error("new request not held off");
  a_wait_idle: assert property (!rw |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_ack_once: assert property (rw && !avs_waitrequest |=> avs_waitrequest || !rw)
    else $error("two answers for one request");
  a_rdata_hold: assert property (!avs_req.read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_pins_quiet: assert property (!scan_end && !avs_req.write && !prog_stop_error |=>
    $stable(output_points) || $changed(fn_out)) else $error("pins moved without cause");
  a_stop_freeze: assert property (stop_q && !avs_req.write |=>
    $stable(output_points) || $changed(fn_out)) else $error("pins moved while stopped");
  a_filt_steady: assert property ((input_points == fn_in) [*4] |=> $stable(fn_in))
    else $error("filtered input moved on a steady pin");
  a_rst_clear: assert property (disable iff (1'b0) srst |=>
    output_points == 8'h00 && fn_in == 16'h0000 && avs_readdata == 32'h0) else $error("reset values");
endmodule : srip_port_chk
bind srip_port srip_port_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_sys(clk_sys), .srst(srst),
  .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .input_points(input_points), .output_points(output_points), .scan_end(scan_end),
  .prog_stop_error(prog_stop_error), .fn_out(fn_out), .fn_in(fn_in));

/* File: testbench/tb_top.sv */
// self-checking testbench of the scan refreshed io port
`timescale 1ns/1ps
module tb_top;
  srip_pkg::srip_avs_req_t req;
  logic clk_sys, srst, scan_end, prog_stop_error, avs_waitrequest;
  logic [31:0] rdata, q;
  logic [15:0] input_points, fn_in, sw;
  logic [7:0] output_points, fn_out;
  int bad_count, checks;
  srip_port #(.TICK_CYCLES(4)) uut (.clk_sys(clk_sys), .srst(srst), .avs_req(req), .avs_readdata(rdata),
    .avs_waitrequest(avs_waitrequest), .input_points(input_points), .output_points(output_points),
    .scan_end(scan_end), .prog_stop_error(prog_stop_error), .fn_out(fn_out), .fn_in(fn_in));
  srip_field field (.clk_sys(clk_sys), .sw(sw), .input_points(input_points));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////
  task summarize;
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one avalon cycle, held until waitrequest is seen low
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{!wr, wr, a, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      $display("[FAIL] %0t bus timeout", $time);
      summarize();
    end
    q = rdata;
    req <= '0;
    @(posedge clk_sys);
  endtask : bus
  task rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task scan;
    scan_end <= 1'b1;
    tick(1);
    scan_end <= 1'b0;
    tick(1);
  endtask : scan
  //////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    scan_end = 1'b0;
    prog_stop_error = 1'b0;
    fn_out = 8'h00;
    sw = 16'h0000;
    req = '0;
    bad_count = 0;
    checks = 0;
    tick(4);
    srst <= 1'b0;
    tick(1);
    rd(srip_pkg::OFS_FILT_LO, srip_pkg::FILT_LO_RST);
    rd(srip_pkg::OFS_FILT_HI, srip_pkg::FILT_HI_RST);
    rd(srip_pkg::OFS_OUT_CFG, 32'h0);
    rd(srip_pkg::OFS_STATUS, 32'h0);
    rd(6'h3C, 32'h0);
    // every filter code, ending on the shortest
    for (int c = 5; c >= 0; c--) begin
      bus(1'b1, srip_pkg::OFS_FILT_HI, {8{4'(c)}});
      rd(srip_pkg::OFS_FILT_HI, {8{4'(c)}});
    end
    bus(1'b1, srip_pkg::OFS_FILT_LO, 32'h0);
    // high-speed points accept in one tick, standard ones need ten
    sw <= 16'hA5C3;
    tick(10);
    rd(srip_pkg::OFS_IN_DIRECT, 32'h0003);
    tick(40);
    rd(srip_pkg::OFS_IN_DIRECT, 32'hA5C3);
    chk(32'(fn_in), 32'hA5C3);
    rd(srip_pkg::OFS_IN_IMAGE, 32'h0);
    bus(1'b1, srip_pkg::OFS_REFRESH_IN, 32'h00FF);
    rd(srip_pkg::OFS_IN_IMAGE, 32'h00C3);
    scan();
    rd(srip_pkg::OFS_IN_IMAGE, 32'hA5C3);
    // output image, direct write and partial refresh
    bus(1'b1, srip_pkg::OFS_OUT_IMAGE, 32'h5A);
    chk(32'(output_points), 32'h0);
    scan();
    chk(32'(output_points), 32'h5A);
    bus(1'b1, srip_pkg::OFS_OUT_DIRECT, 32'h0F03);
    chk(32'(output_points), 32'h53);
    rd(srip_pkg::OFS_OUT_IMAGE, 32'h53);
    bus(1'b1, srip_pkg::OFS_OUT_IMAGE, 32'hFF);
    bus(1'b1, srip_pkg::OFS_REFRESH_OUT, 32'h0402);
    chk(32'(output_points), 32'h5F);
    bus(1'b1, srip_pkg::OFS_REFRESH_OUT, 32'h0506);
    rd(srip_pkg::OFS_OUT_DIRECT, 32'h5F);
    scan();
    chk(32'(output_points), 32'hFF);
    // function ownership, then a stop with mixed hold and clear
    fn_out <= 8'h80;
    bus(1'b1, srip_pkg::OFS_OUT_CFG, 32'hC00F);
    chk(32'(output_points), 32'hBF);
    bus(1'b1, srip_pkg::OFS_OUT_IMAGE, 32'h33);
    scan();
    chk(32'(output_points), 32'hB3);
    prog_stop_error <= 1'b1;
    tick(1);
    prog_stop_error <= 1'b0;
    tick(1);
    chk(32'(output_points), 32'h83);
    bus(1'b1, srip_pkg::OFS_OUT_IMAGE, 32'hFF);
    scan();
    chk(32'(output_points), 32'h83);
    rd(srip_pkg::OFS_STATUS, 32'h1);
    fn_out <= 8'h40;
    tick(1);
    chk(32'(output_points), 32'h43);
    summarize();
  end
endmodule : tb_top
